// ===== rps_monitor.sv
`timescale 1ns/1ps
// Functional notes
// - Lock change and back-channel CRC/sequence flags latch; cleared by reading their register.
// - Parity errors counted in 16 bits, read as high and low bytes.
// - Parity flag sets once the count reaches the programmed threshold.
// - Reading the parity counter clears the count and the parity flag.
// - Parity flag raises the interrupt when enabled.
// - Loss of lock clears parity count and flag by default.
// - Encoding or sequence error latches the encoder fault flag.
// - Encoder fault flag clears on read and raises the interrupt when enabled.
// - Encoder fault only detected with link error counting and threshold above 1.
// - With CRC checking on, failed packets do not update link information.
// - CRC checking applies when disable bit is 0 and capability bit set.
// - Second status register shows frequency steady and input clock absent.
// - Input clock absent when measured frequency is below the low threshold.
// - Frequency steady drops when frequency moves more than the hysteresis.
// - Frequency measured continually, 16-bit result refreshed within 1 ms.
// - Frequency change raises the interrupt when enabled.
// - Lines per frame counted: long packets in CSI-2, line valid in raw.
// - Last frame line count exposed; on change it interrupts and holds until read.
// - Line length in bytes measured; the last line of the frame reported.
// - Line length change interrupts and holds the registers until read.
// - Sensor status relayed; rise and fall status cleared when read.
module rps_monitor
	import rps_pkg::*;
(
	// Clocks and reset
	input  wire logic            i_clk,
	input  wire logic            i_rst,
	input  wire logic            i_link_clk,
	// Register port
	input  wire rps_reg_req_type i_req,
	output logic [7:0]           o_rdata,
	output logic                 o_irq,
	// Decoded link
	input  wire rps_link_in_type i_link
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [1:0]   c0;
		logic [1:0]   c1;
		logic [1:0]   c2;
		logic [1:0]   ctl_f;
		logic [5:0]   tgl;
		logic [2:0]   div;
		logic         lock;
		logic         in_line;
		logic [15:0]  lines;
		logic [15:0]  bytes;
		logic [15:0]  last_len;
		logic [15:0]  frame_lines;
		logic [15:0]  frame_len;
		rps_info_type info;
	} rps_link_state_type;

	typedef struct packed {
		logic [7:0]   gen_cfg;
		logic [7:0]   port_cfg;
		logic [7:0]   link_err;
		logic [7:0]   par_thr;
		logic [7:0]   freq_ctl;
		logic [7:0]   crc_ctl;
		logic [7:0]   rdata;
		logic [7:0]   rise;
		logic [7:0]   fall;
		logic [7:0]   par_snap;
		logic [7:0]   s0;
		logic [7:0]   s1;
		logic [7:0]   s2;
		logic [7:0]   flt;
		logic         lock_chg;
		logic         bcrc;
		logic         bseq;
		logic         par_flag;
		logic         enc;
		logic         fchg;
		logic         steady;
		logic         absent;
		logic         lcnt_hold;
		logic         llen_hold;
		logic [15:0]  par_cnt;
		logic [15:0]  freq;
		logic [15:0]  win;
		logic [15:0]  edges;
		logic [15:0]  lcnt;
		logic [15:0]  llen;
		rps_info_type info;
	} rps_main_state_type;

	rps_link_state_type l_reg;
	rps_link_state_type l_next;
	rps_main_state_type s_reg;
	rps_main_state_type s_next;
	logic [1:0]         lrst_reg;
	logic               l_rst;

	function automatic logic [15:0] abs_diff(input logic [15:0] a, input logic [15:0] b);
		abs_diff = (a > b) ? a - b : b - a;
	endfunction

	function automatic logic [7:0] rd_mux(input rps_main_state_type s, input logic [7:0] a);
		logic [7:0] v;
		v = 8'h00;
		case (a)
			A_GEN_CFG:  v = s.gen_cfg;
			A_PORT_CFG: v = s.port_cfg;
			A_LINK_ERR: v = s.link_err;
			A_PAR_THR:  v = s.par_thr;
			A_STS1: begin
				v[S1_LOCK_CHG] = s.lock_chg;
				v[S1_PAR]      = s.par_flag;
				v[S1_BCRC]     = s.bcrc;
				v[S1_BSEQ]     = s.bseq;
				v[S1_LOCK]     = s.flt[7];
			end
			A_STS2: begin
				v[S2_STEADY] = s.steady;
				v[S2_ABSENT] = s.absent;
				v[S2_FCHG]   = s.fchg;
				v[S2_ENC]    = s.enc;
			end
			A_FREQ_HI:  v = s.freq[15:8];
			A_FREQ_LO:  v = s.freq[7:0];
			A_SEN0:     v = s.info.sensor[7:0];
			A_SEN1:     v = s.info.sensor[15:8];
			A_SEN2:     v = s.info.sensor[23:16];
			A_SEN3:     v = s.info.sensor[31:24];
			A_PAR_HI:   v = s.par_cnt[15:8];
			A_PAR_LO:   v = s.par_snap;
			A_SEN_RISE: v = s.rise;
			A_SEN_FALL: v = s.fall;
			A_DP_A:     v = s.info.dp_a;
			A_DP_B:     v = s.info.dp_b;
			A_SER_ID:   v = s.info.ser_id;
			A_LCNT_HI:  v = s.lcnt[15:8];
			A_LCNT_LO:  v = s.lcnt[7:0];
			A_LLEN_HI:  v = s.llen[15:8];
			A_LLEN_LO:  v = s.llen[7:0];
			A_FREQ_CTL: v = s.freq_ctl;
			A_CRC_CTL:  v = s.crc_ctl;
			default:    v = 8'h00;
		endcase
		return v;
	endfunction

	// ----------------------------------------
	// Link domain
	// ----------------------------------------
	// Reset leaves the link domain only on a link edge, so release is clean there.
	always_ff @(posedge i_link_clk or posedge i_rst) begin
		if (i_rst) begin
			lrst_reg <= 2'b11;
		end else begin
			lrst_reg <= {lrst_reg[0], 1'b0};
		end
	end
	assign l_rst = lrst_reg[1];

	logic l_active;
	logic l_start;
	logic l_end;
	logic l_info_ok;

	always_comb begin
		l_next = l_reg;
		l_next.c0 = {~s_reg.crc_ctl[CRC_DIS] & s_reg.port_cfg[PC_CRC_CAP], s_reg.gen_cfg[GC_CSI]};
		l_next.c1 = l_reg.c0;
		l_next.c2 = l_reg.c1;
		for (int i = 0; i < 2; i++) begin
			if (l_reg.c1[i] == l_reg.c2[i]) begin
				l_next.ctl_f[i] = l_reg.c2[i];
			end
		end
		l_next.lock = i_link.lock;
		l_next.div = l_reg.div + 3'h1;
		// CSI-2 counts long packets, raw mode counts line valid
		l_active = l_reg.ctl_f[0] ? i_link.pkt_active : i_link.line_valid;
		l_start = l_active & ~l_reg.in_line;
		l_end = ~l_active & l_reg.in_line;
		l_next.in_line = l_active;
		if (l_start) begin
			l_next.lines = l_reg.lines + 16'h0001;
		end
		l_next.bytes = l_start ? 16'h0000 : l_reg.bytes;
		if (l_active && i_link.byte_valid) begin
			l_next.bytes = l_next.bytes + 16'h0001;
		end
		if (l_end) begin
			l_next.last_len = l_reg.bytes;
		end
		if (i_link.frame_end) begin
			l_next.frame_lines = l_next.lines;
			l_next.frame_len = l_end ? l_reg.bytes : l_reg.last_len;
			l_next.lines = 16'h0000;
		end
		l_info_ok = i_link.info_valid & (~l_reg.ctl_f[1] | i_link.info_crc_ok);
		if (l_info_ok) begin
			l_next.info = i_link.info;
		end
		// Pulses become toggles; pulses closer than a few link cycles can be lost
		l_next.tgl = l_reg.tgl ^ {i_link.frame_end, l_info_ok, i_link.bcc_seq, i_link.bcc_crc,
			i_link.enc_err | i_link.seq_err, i_link.par_err};
	end

	always_ff @(posedge i_link_clk or posedge l_rst) begin
		if (l_rst) begin
			l_reg <= '0;
		end else begin
			l_reg <= l_next;
		end
	end

	a_info_gate: assert property (@(posedge i_link_clk) disable iff (l_rst)
		(i_link.info_valid && l_reg.ctl_f[1] && !i_link.info_crc_ok) |=> $stable(l_reg.info))
		else $error("failed CRC packet updated link info");

	// ----------------------------------------
	// Register domain
	// ----------------------------------------
	logic [7:0]  ev;
	logic        rd_sts1;
	logic        rd_sts2;
	logic        rd_par;
	logic        lock_fall;
	logic        par_ev;
	logic        par_clr;
	logic        enc_allow;
	logic [15:0] par_base;
	logic [15:0] meas;
	logic        lc_hold;
	logic        ll_hold;

	always_comb begin
		s_next = s_reg;
		// Bits: 0 parity, 1 encoder, 2 bcc crc, 3 bcc seq, 4 info, 5 frame, 6 divider, 7 lock
		s_next.s0 = {l_reg.lock, l_reg.div[2], l_reg.tgl};
		s_next.s1 = s_reg.s0;
		s_next.s2 = s_reg.s1;
		for (int i = 0; i < 8; i++) begin
			if (s_reg.s1[i] == s_reg.s2[i]) begin
				s_next.flt[i] = s_reg.s2[i];
			end
		end
		ev = s_next.flt ^ s_reg.flt;
		rd_sts1 = i_req.rd && i_req.addr == A_STS1;
		rd_sts2 = i_req.rd && i_req.addr == A_STS2;
		rd_par = i_req.rd && i_req.addr == A_PAR_HI;
		lock_fall = ev[7] & ~s_next.flt[7];

		if (i_req.wr) begin
			case (i_req.addr)
				A_GEN_CFG:  s_next.gen_cfg = i_req.wdata;
				A_PORT_CFG: s_next.port_cfg = i_req.wdata;
				A_LINK_ERR: s_next.link_err = i_req.wdata;
				A_PAR_THR:  s_next.par_thr = i_req.wdata;
				A_FREQ_CTL: s_next.freq_ctl = i_req.wdata;
				A_CRC_CTL:  s_next.crc_ctl = i_req.wdata;
				default:    s_next.rdata = s_reg.rdata;
			endcase
		end
		s_next.rdata = i_req.rd ? rd_mux(s_reg, i_req.addr) : s_reg.rdata;

		// A new event in the clearing cycle wins over the clear
		s_next.lock_chg = (s_reg.lock_chg & ~rd_sts1) | ev[7];
		s_next.bcrc = (s_reg.bcrc & ~rd_sts1) | ev[2];
		s_next.bseq = (s_reg.bseq & ~rd_sts1) | ev[3];

		// Below threshold 2 loss of lock masks encoder faults anyway
		enc_allow = s_reg.link_err[LE_EN] && s_reg.link_err[2:0] > 3'h1;
		s_next.enc = (s_reg.enc & ~rd_sts2) | (ev[1] & enc_allow);

		// Counting continues while a read is in flight, so reads are exact only with checking off
		par_ev = ev[0] & s_reg.gen_cfg[GC_PAR_EN];
		par_clr = rd_par | (lock_fall & ~s_reg.port_cfg[PC_KEEP_PAR]);
		par_base = par_clr ? 16'h0000 : s_reg.par_cnt;
		s_next.par_cnt = (par_ev && par_base != 16'hFFFF) ? par_base + 16'h0001 : par_base;
		s_next.par_flag = (s_reg.par_flag & ~par_clr) |
			(s_reg.par_thr != 8'h00 && s_next.par_cnt >= {8'h00, s_reg.par_thr});
		if (rd_par) begin
			s_next.par_snap = s_reg.par_cnt[7:0];
		end

		meas = s_reg.edges + {15'h0000, ev[6]};
		s_next.fchg = s_reg.fchg & ~rd_sts2;
		if (s_reg.win == 16'(FREQ_WIN_CYC - 1)) begin
			s_next.win = 16'h0000;
			s_next.edges = 16'h0000;
			s_next.freq = meas;
			s_next.absent = meas < {12'h000, s_reg.freq_ctl[3:0]};
			s_next.steady = abs_diff(meas, s_reg.freq) <= {12'h000, s_reg.freq_ctl[7:4]};
			if (abs_diff(meas, s_reg.freq) > {12'h000, s_reg.freq_ctl[7:4]}) begin
				s_next.fchg = 1'b1;
			end
		end else begin
			s_next.win = s_reg.win + 16'h0001;
			s_next.edges = meas;
		end

		s_next.rise = s_reg.rise & ~{8{i_req.rd && i_req.addr == A_SEN_RISE}};
		s_next.fall = s_reg.fall & ~{8{i_req.rd && i_req.addr == A_SEN_FALL}};
		if (ev[4]) begin
			s_next.info = l_reg.info;
			s_next.rise = s_next.rise | (l_reg.info.sensor[7:0] & ~s_reg.info.sensor[7:0]);
			s_next.fall = s_next.fall | (~l_reg.info.sensor[7:0] & s_reg.info.sensor[7:0]);
		end

		lc_hold = s_reg.lcnt_hold & ~(i_req.rd && i_req.addr == A_LCNT_LO);
		ll_hold = s_reg.llen_hold & ~(i_req.rd && i_req.addr == A_LLEN_LO);
		s_next.lcnt_hold = lc_hold;
		s_next.llen_hold = ll_hold;
		if (ev[5] && !lc_hold) begin
			s_next.lcnt = l_reg.frame_lines;
			s_next.lcnt_hold = s_reg.port_cfg[PC_LIN_IRQ] && l_reg.frame_lines != s_reg.lcnt;
		end
		if (ev[5] && !ll_hold) begin
			s_next.llen = l_reg.frame_len;
			s_next.llen_hold = s_reg.port_cfg[PC_LIN_IRQ] && l_reg.frame_len != s_reg.llen;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			s_reg <= '0;
			s_reg.gen_cfg <= GEN_CFG_RST;
			s_reg.port_cfg <= PORT_CFG_RST;
			s_reg.link_err <= LINK_ERR_RST;
			s_reg.par_thr <= PAR_THR_RST;
			s_reg.freq_ctl <= FREQ_CTL_RST;
			s_reg.crc_ctl <= CRC_CTL_RST;
			s_reg.absent <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign o_rdata = s_reg.rdata;
	assign o_irq = (s_reg.par_flag & s_reg.port_cfg[PC_PAR_IRQ]) |
		(s_reg.enc & s_reg.port_cfg[PC_ENC_IRQ]) |
		(s_reg.fchg & s_reg.port_cfg[PC_FRQ_IRQ]) |
		((s_reg.lcnt_hold | s_reg.llen_hold) & s_reg.port_cfg[PC_LIN_IRQ]) |
		((|s_reg.rise | |s_reg.fall) & s_reg.port_cfg[PC_SEN_IRQ]);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	a_par_clear: assert property (rd_par |=> s_reg.par_cnt <= 16'h0001)
		else $error("parity count not cleared by read");
	a_par_sat: assert property ((s_reg.par_cnt == 16'hFFFF && !par_clr) |=> s_reg.par_cnt == 16'hFFFF)
		else $error("parity count wrapped");
	a_par_thresh: assert property ((s_reg.par_thr != 8'h00 && s_reg.par_cnt >= {8'h00, s_reg.par_thr})
		|=> s_reg.par_flag || $past(par_clr))
		else $error("parity flag missing at threshold");
	a_lock_loss: assert property ((lock_fall && !s_reg.port_cfg[PC_KEEP_PAR]) |=> s_reg.par_cnt <= 16'h0001)
		else $error("parity count kept over lock loss");
	a_par_irq: assert property ((s_reg.par_flag && s_reg.port_cfg[PC_PAR_IRQ]) |-> o_irq)
		else $error("parity interrupt missing");
	a_enc_gate: assert property ((!enc_allow && !rd_sts2) |=> $stable(s_reg.enc))
		else $error("encoder flag changed while detection disabled");
	a_sts1_clear: assert property ((rd_sts1 && ev[2:1] == 2'b00 && !ev[7] && !ev[3])
		|=> !s_reg.lock_chg && !s_reg.bcrc && !s_reg.bseq)
		else $error("status one flags not cleared by read");
	a_freq_absent: assert property ((s_reg.win == 16'(FREQ_WIN_CYC - 1))
		|=> s_reg.absent == (s_reg.freq < {12'h000, s_reg.freq_ctl[3:0]}))
		else $error("clock absent disagrees with measurement");
	a_freq_refresh: assert property ($rose(s_reg.win == 16'h0000) |-> ##[1:600] s_reg.win == 16'h0000)
		else $error("frequency window overran");
	a_line_hold: assert property ((s_reg.lcnt_hold && !(i_req.rd && i_req.addr == A_LCNT_LO))
		|=> $stable(s_reg.lcnt))
		else $error("held line count changed");

endmodule

// ===== rps_pkg.sv
package rps_pkg;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] A_GEN_CFG   = 8'h02;
	localparam logic [7:0] A_PORT_CFG  = 8'h4A;
	localparam logic [7:0] A_LINK_ERR  = 8'h4B;
	localparam logic [7:0] A_PAR_THR   = 8'h4C;
	localparam logic [7:0] A_STS1      = 8'h4D;
	localparam logic [7:0] A_STS2      = 8'h4E;
	localparam logic [7:0] A_FREQ_HI   = 8'h4F;
	localparam logic [7:0] A_FREQ_LO   = 8'h50;
	localparam logic [7:0] A_SEN0      = 8'h51;
	localparam logic [7:0] A_SEN1      = 8'h52;
	localparam logic [7:0] A_SEN2      = 8'h53;
	localparam logic [7:0] A_SEN3      = 8'h54;
	localparam logic [7:0] A_PAR_HI    = 8'h55;
	localparam logic [7:0] A_PAR_LO    = 8'h56;
	localparam logic [7:0] A_SEN_RISE  = 8'h57;
	localparam logic [7:0] A_SEN_FALL  = 8'h58;
	localparam logic [7:0] A_DP_A      = 8'h59;
	localparam logic [7:0] A_DP_B      = 8'h5A;
	localparam logic [7:0] A_SER_ID    = 8'h5B;
	localparam logic [7:0] A_LCNT_HI   = 8'h73;
	localparam logic [7:0] A_LCNT_LO   = 8'h74;
	localparam logic [7:0] A_LLEN_HI   = 8'h75;
	localparam logic [7:0] A_LLEN_LO   = 8'h76;
	localparam logic [7:0] A_FREQ_CTL  = 8'h77;
	localparam logic [7:0] A_CRC_CTL   = 8'hBA;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int GC_PAR_EN   = 0;
	localparam int GC_CSI      = 1;
	localparam int PC_PAR_IRQ  = 0;
	localparam int PC_ENC_IRQ  = 1;
	localparam int PC_FRQ_IRQ  = 2;
	localparam int PC_LIN_IRQ  = 3;
	localparam int PC_CRC_CAP  = 4;
	localparam int PC_KEEP_PAR = 5;
	localparam int PC_SEN_IRQ  = 6;
	localparam int LE_EN       = 3;
	localparam int S1_LOCK_CHG = 0;
	localparam int S1_PAR      = 1;
	localparam int S1_BCRC     = 2;
	localparam int S1_BSEQ     = 3;
	localparam int S1_LOCK     = 4;
	localparam int S2_STEADY   = 1;
	localparam int S2_ABSENT   = 2;
	localparam int S2_FCHG     = 3;
	localparam int S2_ENC      = 5;
	localparam int CRC_DIS     = 7;

	// ----------------------------------------
	// Reset values and timing
	// ----------------------------------------
	localparam logic [7:0] GEN_CFG_RST  = 8'h01;
	localparam logic [7:0] PORT_CFG_RST = 8'h00;
	localparam logic [7:0] LINK_ERR_RST = 8'h00;
	localparam logic [7:0] PAR_THR_RST  = 8'h01;
	localparam logic [7:0] FREQ_CTL_RST = 8'h25;
	localparam logic [7:0] CRC_CTL_RST  = 8'h00;
	localparam int CLK_NS       = 8;
	localparam int FREQ_WIN_NS  = 4000;
	localparam int FREQ_WIN_CYC = FREQ_WIN_NS / CLK_NS;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic [7:0]  dp_a;
		logic [7:0]  dp_b;
		logic [7:0]  ser_id;
		logic [31:0] sensor;
	} rps_info_type;

	typedef struct packed {
		logic         par_err;
		logic         enc_err;
		logic         seq_err;
		logic         bcc_crc;
		logic         bcc_seq;
		logic         lock;
		logic         line_valid;
		logic         pkt_active;
		logic         byte_valid;
		logic         frame_end;
		logic         info_valid;
		logic         info_crc_ok;
		rps_info_type info;
	} rps_link_in_type;

	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} rps_reg_req_type;

endpackage

// ===== rps_ser_model.sv
`timescale 1ns/1ps
module rps_ser_model
	import rps_pkg::*;
(
	// Link side
	output logic            o_link_clk,
	output rps_link_in_type o_link
);
	logic run;

	// ----------------------------------------
	// Link clock
	// ----------------------------------------
	// Free running: the frequency monitor needs edges between frames too
	initial begin
		run        = 1'b1;
		o_link_clk = 1'b0;
		o_link     = '0;
		#5;
		forever begin
			#6;
			if (run) begin
				o_link_clk = ~o_link_clk;
			end
		end
	end

	// ----------------------------------------
	// Traffic
	// ----------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge o_link_clk);
	endtask

	// Order: parity, encoding, sequence, bcc crc, bcc sequence
	task automatic errs(input logic [4:0] m);
		@(posedge o_link_clk);
		{o_link.par_err, o_link.enc_err, o_link.seq_err, o_link.bcc_crc, o_link.bcc_seq} <= m;
		@(posedge o_link_clk);
		{o_link.par_err, o_link.enc_err, o_link.seq_err, o_link.bcc_crc, o_link.bcc_seq} <= 5'h00;
		tick(6);
	endtask

	task automatic set_lock(input logic v);
		@(posedge o_link_clk);
		o_link.lock <= v;
		tick(8);
	endtask

	// One line of n bytes, as a long packet or as a line valid pulse
	// Idle cycles open the line with no byte, so the byte count must skip them
	task automatic line(input logic pkt, input int n, input int idle = 0);
		@(posedge o_link_clk);
		o_link.pkt_active <= pkt;
		o_link.line_valid <= !pkt;
		o_link.byte_valid <= (idle == 0);
		if (idle > 0) begin
			tick(idle);
			o_link.byte_valid <= 1'b1;
		end
		tick(n);
		o_link.pkt_active <= 1'b0;
		o_link.line_valid <= 1'b0;
		o_link.byte_valid <= 1'b0;
		tick(4);
	endtask

	task automatic frame_end();
		@(posedge o_link_clk);
		o_link.frame_end <= 1'b1;
		@(posedge o_link_clk);
		o_link.frame_end <= 1'b0;
		tick(8);
	endtask

	task automatic send_info(input rps_info_type v, input logic ok);
		@(posedge o_link_clk);
		o_link.info        <= v;
		o_link.info_crc_ok <= ok;
		o_link.info_valid  <= 1'b1;
		@(posedge o_link_clk);
		o_link.info_valid  <= 1'b0;
		tick(8);
	endtask
endmodule

// ===== rps_monitor_tb_top.sv
`timescale 1ns/1ps
module rps_monitor_tb_top
	import rps_pkg::*;
;
	logic            i_clk;
	logic            i_rst;
	rps_reg_req_type req;
	logic [7:0]      rdata;
	logic            irq;
	logic            link_clk;
	rps_link_in_type link;
	logic [7:0]      d;
	logic [15:0]     f;
	int              n_errors;
	int              num_checks;

	rps_monitor u_dut (
		.i_clk      (i_clk),
		.i_rst      (i_rst),
		.i_link_clk (link_clk),
		.i_req      (req),
		.o_rdata    (rdata),
		.o_irq      (irq),
		.i_link     (link)
	);

	rps_ser_model u_ser (
		.o_link_clk (link_clk),
		.o_link     (link)
	);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	initial begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk);
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
			n_errors++;
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge i_clk);
		req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: v};
		@(posedge i_clk);
		req.wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge i_clk);
		req.rd   <= 1'b1;
		req.addr <= a;
		@(posedge i_clk);
		req.rd <= 1'b0;
		@(posedge i_clk);
		d = rdata;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		rd(a);
		chk({8'h00, d & m}, {8'h00, e});
	endtask

	task automatic conclude();
		$display("checks=%0d errors=%0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset_values();
		rdc(A_GEN_CFG, 8'hFF, GEN_CFG_RST);
		rdc(A_PORT_CFG, 8'hFF, PORT_CFG_RST);
		rdc(A_PAR_THR, 8'hFF, PAR_THR_RST);
		rdc(A_FREQ_CTL, 8'hFF, FREQ_CTL_RST);
		rdc(A_CRC_CTL, 8'hFF, CRC_CTL_RST);
		rdc(A_STS2, 8'h06, 8'h04);
		wr(A_SEN0, 8'hFF);
		rdc(A_SEN0, 8'hFF, 8'h00);
		rdc(8'hFF, 8'hFF, 8'h00);
		chk({15'h0, irq}, 16'h0000);
	endtask

	task automatic t_status_flags();
		u_ser.set_lock(1'b1);
		u_ser.errs(5'b00011);
		rdc(A_STS1, 8'hFF, 8'h1D);
		rdc(A_STS1, 8'hFF, 8'h10);
	endtask

	task automatic t_parity();
		wr(A_PAR_THR, 8'h03);
		wr(A_PORT_CFG, 8'h01);
		u_ser.errs(5'b10000);
		u_ser.errs(5'b10000);
		rdc(A_STS1, 8'h02, 8'h00);
		chk({15'h0, irq}, 16'h0000);
		u_ser.errs(5'b10000);
		cyc(4);
		chk({15'h0, irq}, 16'h0001);
		rdc(A_STS1, 8'h02, 8'h02);
		wr(A_GEN_CFG, 8'h00);
		rdc(A_PAR_HI, 8'hFF, 8'h00);
		rdc(A_PAR_LO, 8'hFF, 8'h03);
		rdc(A_STS1, 8'h02, 8'h00);
		chk({15'h0, irq}, 16'h0001 ^ 16'h0001);
		wr(A_GEN_CFG, GEN_CFG_RST);
		wr(A_PORT_CFG, 8'h00);
	endtask

	task automatic t_lock_loss();
		u_ser.errs(5'b10000);
		u_ser.errs(5'b10000);
		u_ser.set_lock(1'b0);
		u_ser.set_lock(1'b1);
		rdc(A_PAR_HI, 8'hFF, 8'h00);
		rdc(A_PAR_LO, 8'hFF, 8'h00);
		rdc(A_STS1, 8'h01, 8'h01);
	endtask

	task automatic t_encoder();
		wr(A_LINK_ERR, 8'h09);
		u_ser.errs(5'b01000);
		rdc(A_STS2, 8'h20, 8'h00);
		wr(A_LINK_ERR, 8'h0A);
		wr(A_PORT_CFG, 8'h02);
		u_ser.errs(5'b01000);
		cyc(4);
		chk({15'h0, irq}, 16'h0001);
		rdc(A_STS2, 8'h20, 8'h20);
		rdc(A_STS2, 8'h20, 8'h00);
		u_ser.errs(5'b00100);
		rdc(A_STS2, 8'h20, 8'h20);
		wr(A_PORT_CFG, 8'h00);
	endtask

	task automatic t_crc_gate();
		rps_info_type a;
		rps_info_type b;
		a = '{dp_a: 8'hA5, dp_b: 8'h3C, ser_id: 8'h5E, sensor: 32'h0000_0001};
		b = '{dp_a: 8'h11, dp_b: 8'h22, ser_id: 8'h33, sensor: 32'h0000_0000};
		u_ser.send_info(a, 1'b0);
		rdc(A_DP_A, 8'hFF, 8'hA5);
		rdc(A_DP_B, 8'hFF, 8'h3C);
		rdc(A_SER_ID, 8'hFF, 8'h5E);
		rdc(A_SEN0, 8'hFF, 8'h01);
		rdc(A_SEN_RISE, 8'h01, 8'h01);
		rdc(A_SEN_RISE, 8'h01, 8'h00);
		wr(A_PORT_CFG, 8'h10);
		// Link-side control copies need a few link edges to settle
		u_ser.tick(4);
		u_ser.send_info(b, 1'b0);
		rdc(A_DP_A, 8'hFF, 8'hA5);
		rdc(A_SEN0, 8'hFF, 8'h01);
		wr(A_CRC_CTL, 8'h80);
		u_ser.tick(4);
		u_ser.send_info(b, 1'b0);
		rdc(A_DP_A, 8'hFF, 8'h11);
		rdc(A_SER_ID, 8'hFF, 8'h33);
		rdc(A_SEN_FALL, 8'h01, 8'h01);
		rdc(A_SEN_FALL, 8'h01, 8'h00);
		wr(A_CRC_CTL, 8'h00);
		wr(A_PORT_CFG, 8'h00);
	endtask

	task automatic t_lines();
		u_ser.line(1'b1, 9);
		u_ser.line(1'b0, 4);
		u_ser.line(1'b0, 6, 3);
		u_ser.frame_end();
		rdc(A_LCNT_HI, 8'hFF, 8'h00);
		rdc(A_LCNT_LO, 8'hFF, 8'h02);
		rdc(A_LLEN_HI, 8'hFF, 8'h00);
		rdc(A_LLEN_LO, 8'hFF, 8'h06);
		wr(A_GEN_CFG, 8'h03);
		u_ser.tick(4);
		u_ser.line(1'b0, 7);
		u_ser.line(1'b1, 5);
		u_ser.line(1'b1, 3);
		u_ser.frame_end();
		rdc(A_LCNT_LO, 8'hFF, 8'h02);
		rdc(A_LLEN_LO, 8'hFF, 8'h03);
		wr(A_PORT_CFG, 8'h08);
		u_ser.line(1'b1, 8);
		u_ser.frame_end();
		chk({15'h0, irq}, 16'h0001);
		u_ser.line(1'b1, 2);
		u_ser.line(1'b1, 2);
		u_ser.line(1'b1, 2);
		u_ser.frame_end();
		rdc(A_LCNT_HI, 8'hFF, 8'h00);
		rdc(A_LCNT_LO, 8'hFF, 8'h01);
		rdc(A_LLEN_HI, 8'hFF, 8'h00);
		rdc(A_LLEN_LO, 8'hFF, 8'h08);
		wr(A_PORT_CFG, 8'h00);
		wr(A_GEN_CFG, GEN_CFG_RST);
	endtask

	task automatic t_freq();
		int n;
		cyc(3 * FREQ_WIN_CYC);
		rdc(A_STS2, 8'h06, 8'h02);
		rd(A_FREQ_HI);
		f[15:8] = d;
		rd(A_FREQ_LO);
		f[7:0] = d;
		chk({15'h0, f >= 16'd80 && f <= 16'd86}, 16'h0001);
		rdc(A_STS2, 8'h08, 8'h00);
		wr(A_PORT_CFG, 8'h04);
		chk({15'h0, irq}, 16'h0000);
		u_ser.run = 1'b0;
		// The jump shows within two windows; steady must be low at that same window
		n = 0;
		while (!irq && n < 2 * FREQ_WIN_CYC) begin
			cyc(1);
			n++;
		end
		chk({15'h0, irq}, 16'h0001);
		rdc(A_STS2, 8'h0A, 8'h08);
		cyc(2 * FREQ_WIN_CYC);
		rdc(A_STS2, 8'h04, 8'h04);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		n_errors   = 0;
		num_checks = 0;
		i_rst      = 1'b1;
		req        = '0;
		// Link domain leaves reset two link edges after release
		cyc(3);
		i_rst <= 1'b0;
		cyc(4);
		t_reset_values();
		t_status_flags();
		t_parity();
		t_lock_loss();
		t_encoder();
		t_crc_gate();
		t_lines();
		t_freq();
		conclude();
	end

	initial begin
		cyc(30000);
		n_errors++;
		conclude();
	end
endmodule
